// ---- logic/pesl_link.sv ----
// device end of the programming executive serial link
// Function
// - one response per fully processed command
// - clock pin is input only
// - device data changes on falling edges
// - sixteen bit words, msb first
// - drive data high while processing
// - drive data low 15 us when ready
// - no timeout while sending response
// - header is 4-bit opcode, 12-bit length
// - receive exactly length words, header included, before processing; length 0 acts as 1
// - unknown opcode gets a negative acknowledge
module pesl_link import pesl_pkg::*; (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // serial pins, asynchronous to ref_clk
  input  wire logic prog_serial_clock_pin,
  input  wire logic prog_serial_data_pin_i,
  output logic      prog_serial_data_pin_o,
  output logic      prog_serial_data_pin_oe,
  // status
  output logic      busy,
  output logic [3:0] last_opcode
);
  // synchronisers; first stages feed only second stages
  logic clk_s1_q, clk_s2_q, clk_s3_q;
  logic dat_s1_q, dat_s2_q;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      clk_s1_q <= 1'b0;
      clk_s2_q <= 1'b0;
      clk_s3_q <= 1'b0;
      dat_s1_q <= 1'b0;
      dat_s2_q <= 1'b0;
    end else begin
      clk_s1_q <= prog_serial_clock_pin;
      clk_s2_q <= clk_s1_q;
      clk_s3_q <= clk_s2_q;
      dat_s1_q <= prog_serial_data_pin_i;
      dat_s2_q <= dat_s1_q;
    end
  end

  // edge detection on the synchronised link clock; only falls matter,
  // rising edges are the programmer's sampling points
  logic sck_fall;
  assign sck_fall = !clk_s2_q && clk_s3_q;

  // main state
  pesl_state_e      st_q, st_d;
  logic [WORD_W-1:0] sh_q, sh_d;      // shift register
  logic [4:0]        bit_q, bit_d;    // bits done in current word
  logic [LEN_W-1:0]  left_q, left_d;  // words still to receive
  logic [3:0]        opc_q, opc_d;    // opcode of current command
  logic [15:0]       tmr_q, tmr_d;    // busy and ready timer
  logic [1:0]        gen_q, gen_d;    // response words pushed
  logic              dout_q, dout_d;  // data pin output
  logic              oe_q, oe_d;      // data pin enable
  // fifo hookup
  pesl_word_s        push_w, pop_w;
  logic              push_v, push_r, pop_v, pop_r;

  // decoding of accepted opcodes
  function automatic logic opc_ok(input logic [3:0] o);
    return (o == OPC_SANITY) || (o == OPC_VERSION);
  endfunction

  // response word table by index
  function automatic logic [15:0] resp_word(input logic [3:0] o,
                                            input logic [1:0] i);
    logic [15:0] w;
    w = 16'h0000;
    if (i == 2'd0) begin
      w = opc_ok(o) ? ACK_HDR : NACK_HDR;
      w = w | {4'h0, o, 8'h00}; // opcode echoed in bits 11:8
    end else if (i == 2'd1) begin
      w = RESP_LEN2;
    end
    if (o == OPC_VERSION && i == 2'd1) begin
      w = VERSION_W;
    end
    return w;
  endfunction

  // fifo carries response words to the transmitter
  pesl_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_valid  (push_v),
    .in_ready  (push_r),
    .in_data   (push_w),
    .out_valid (pop_v),
    .out_ready (pop_r),
    .out_data  (pop_w)
  );

  // next-state logic
  always_comb begin
    st_d   = st_q;
    sh_d   = sh_q;
    bit_d  = bit_q;
    left_d = left_q;
    opc_d  = opc_q;
    tmr_d  = tmr_q;
    gen_d  = gen_q;
    dout_d = dout_q;
    oe_d   = oe_q;
    push_v = 1'b0;
    push_w.data = resp_word(opc_q, gen_q);
    pop_r  = 1'b0;
    unique case (st_q)
      ST_RX_HDR, ST_RX_DATA: begin
        oe_d = 1'b0; // programmer owns the pin
        if (sck_fall) begin
          sh_d  = {sh_q[WORD_W-2:0], dat_s2_q};
          bit_d = bit_q + 5'd1;
          if (bit_q == 5'd15) begin
            bit_d = 5'd0;
            if (st_q == ST_RX_HDR) begin
              opc_d  = sh_d[OPC_MSB -: OPC_W];
              left_d = sh_d[LEN_MSB:0] - 12'd1;
            end else begin
              left_d = left_q - 12'd1;
            end
            // header counts as one of the length words
            if ((st_q == ST_RX_HDR && sh_d[LEN_MSB:0] <= 12'd1) ||
                (st_q == ST_RX_DATA && left_q == 12'd1)) begin
              st_d  = ST_BUSY;
              tmr_d = 16'd0;
              gen_d = 2'd0;
            end else begin
              st_d = ST_RX_DATA;
            end
          end
        end
      end
      ST_BUSY: begin
        oe_d   = 1'b1;
        dout_d = 1'b1;
        tmr_d  = tmr_q + 16'd1;
        // build the two-word response, nack if unknown
        if (gen_q != 2'd2) begin
          push_v = 1'b1;
          if (push_r) begin
            gen_d = gen_q + 2'd1;
          end
        end else if (tmr_q >= 16'(PROC_CYC)) begin
          st_d   = ST_READY;
          tmr_d  = 16'd0;
          dout_d = 1'b0;
        end
      end
      ST_READY: begin
        dout_d = 1'b0;
        tmr_d  = tmr_q + 16'd1;
        if (tmr_q == 16'(READY_CYC - 1)) begin
          st_d   = ST_TX;
          sh_d   = pop_w.data;
          pop_r  = 1'b1;
          bit_d  = 5'd0;
          dout_d = pop_w.data[WORD_W-1];
        end
      end
      ST_TX: begin
        // waits for the programmer's clock forever
        if (sck_fall) begin
          bit_d = bit_q + 5'd1;
          sh_d  = {sh_q[WORD_W-2:0], 1'b0};
          if (bit_q == 5'd15) begin
            bit_d = 5'd0;
            if (pop_v) begin
              sh_d   = pop_w.data;
              pop_r  = 1'b1;
              dout_d = pop_w.data[WORD_W-1];
            end else begin
              st_d = ST_RX_HDR;
              oe_d = 1'b0;
            end
          end else begin
            dout_d = sh_q[WORD_W-2];
          end
        end
      end
      default: begin
        st_d = ST_RX_HDR;
        oe_d = 1'b0;
      end
    endcase
  end

  // state registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q   <= ST_RX_HDR;
      sh_q   <= 16'h0000;
      bit_q  <= 5'h00;
      left_q <= 12'h000;
      opc_q  <= 4'h0;
      tmr_q  <= 16'h0000;
      gen_q  <= 2'h0;
      dout_q <= 1'b0;
      oe_q   <= 1'b0;
    end else begin
      st_q   <= st_d;
      sh_q   <= sh_d;
      bit_q  <= bit_d;
      left_q <= left_d;
      opc_q  <= opc_d;
      tmr_q  <= tmr_d;
      gen_q  <= gen_d;
      dout_q <= dout_d;
      oe_q   <= oe_d;
    end
  end

  // pin and status outputs
  assign prog_serial_data_pin_o  = dout_q;
  assign prog_serial_data_pin_oe = oe_q;
  assign busy        = (st_q == ST_BUSY);
  assign last_opcode = opc_q;
endmodule

// ---- logic/pesl_pkg.sv ----
// package for the programming executive serial link
package pesl_pkg;
  // word format
  localparam int WORD_W     = 16;                // link word width
  localparam int OPC_W      = 4;                 // opcode width
  localparam int LEN_W      = 12;                // length field width
  localparam int OPC_MSB    = 15;                // opcode top bit
  localparam int LEN_MSB    = 11;                // length top bit
  localparam int FIFO_DEPTH = 16;                // response fifo depth
  // timing
  localparam int CLK_MHZ    = 125;               // ref_clk rate
  localparam int READY_NS   = 15000;             // ready-low time, ns
  localparam int READY_CYC  = (READY_NS * CLK_MHZ) / 1000; // round down
  localparam int PROC_CYC   = 4;                 // minimum busy time
  // opcodes that are accepted, and response words
  localparam logic [3:0] OPC_SANITY  = 4'h0;     // sanity check
  localparam logic [3:0] OPC_VERSION = 4'hB;     // version query
  localparam logic [15:0] ACK_HDR    = 16'h1000; // pass response header
  localparam logic [15:0] NACK_HDR   = 16'h2000; // fail response header
  localparam logic [15:0] RESP_LEN2  = 16'h0002; // two-word length word
  localparam logic [15:0] VERSION_W  = 16'h0001; // arbitrary version value

  // link states
  typedef enum logic [2:0] {
    ST_RX_HDR  = 3'b000,
    ST_RX_DATA = 3'b001,
    ST_BUSY    = 3'b010,
    ST_READY   = 3'b011,
    ST_TX      = 3'b100
  } pesl_state_e;

  // one response word on its way to the link
  typedef struct packed {
    logic [WORD_W-1:0] data;
  } pesl_word_s;
endpackage

// ---- logic/pesl_fifo.sv ----
// small synchronous fifo for response words
module pesl_fifo import pesl_pkg::*; #(
  parameter int WIDTH = WORD_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // write side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // read side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];   // storage
  logic [AW-1:0]    wp_q, wp_d;    // write pointer
  logic [AW-1:0]    rp_q, rp_d;    // read pointer
  logic [AW:0]      cnt_q, cnt_d;  // fill count
  logic             wr, rd;

  // honest full and empty from the count
  always_comb begin
    in_ready  = (cnt_q != (AW+1)'(DEPTH));
    out_valid = (cnt_q != '0);
    out_data  = mem[rp_q];
    wr        = in_valid && in_ready;
    rd        = out_valid && out_ready;
    wp_d      = wr ? wp_q + 1'b1 : wp_q;
    rp_d      = rd ? rp_q + 1'b1 : rp_q;
    cnt_d     = cnt_q + (AW+1)'(wr) - (AW+1)'(rd);
  end

  // pointers and count
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  // storage has no reset; it is only read when valid
  always_ff @(posedge ref_clk) begin
    if (wr) begin
      mem[wp_q] <= in_data;
    end
  end
endmodule

// ---- tb/pesl_link_monitor.sv ----
// assertion checker for the link device end
module pesl_link_monitor import pesl_pkg::*; (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       rst,
  // serial pins
  input wire logic       prog_serial_clock_pin,
  input wire logic       prog_serial_data_pin_i,
  input wire logic       prog_serial_data_pin_o,
  input wire logic       prog_serial_data_pin_oe,
  // status
  input wire logic       busy,
  input wire logic [3:0] last_opcode
);
  timeunit 1ns;
  timeprecision 100ps;
  logic        oe, d; // short names for the pin drive
  logic        arm_q; // busy seen, ready low not yet
  logic [11:0] n_q;   // cycles into ready low
  assign oe = prog_serial_data_pin_oe;
  assign d  = prog_serial_data_pin_o;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // times the ready-low window after busy; first bit may also be low
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      arm_q <= 1'b0;
      n_q   <= 12'h000;
    end else begin
      arm_q <= busy | (arm_q & ~(oe & ~d));
      if (arm_q & ~busy & oe & ~d)
        n_q <= 12'h001;
      else if (n_q != 12'h000)
        n_q <= (n_q == 12'(READY_CYC - 1)) ? 12'h000 : n_q + 12'h001;
    end
  end
  a_busy_high: assert property (busy && $past(busy) |-> oe && d)
    else $error("pin not high while busy");
  a_busy_min: assert property ($rose(busy) |-> busy[*4])
    else $error("busy too short");
  a_busy_end: assert property ($rose(busy) |-> ##[4:40] !busy)
    else $error("busy too long");
  a_busy_cause: assert property ($rose(busy) |-> !$past(oe))
    else $error("busy while sending");
  a_ready_go: assert property ($fell(busy) |-> ##[0:2] (oe && !d))
    else $error("no ready low");
  a_ready_hold: assert property (n_q != 12'h000 |-> oe && !d)
    else $error("ready low too short");
  a_tx_steady: assert property (oe && !busy && !arm_q &&
    n_q == 12'h000 && prog_serial_clock_pin &&
    $past(prog_serial_clock_pin, 4) |-> $stable(d))
    else $error("data moved in clock high");
  a_pin_free: assert property ($fell(oe) |-> !busy && !arm_q)
    else $error("released early");
  a_opc_hold: assert property (busy && $past(busy) |->
    $stable(last_opcode))
    else $error("opcode moved while busy");
endmodule
bind pesl_link pesl_link_monitor i_pesl_link_monitor (.ref_clk, .rst,
  .prog_serial_clock_pin, .prog_serial_data_pin_i, .prog_serial_data_pin_o,
  .prog_serial_data_pin_oe, .busy, .last_opcode);

// ---- tb/pesl_prog_model.sv ----
// programmer model: serial master of the link
module pesl_prog_model (
  // serial pins
  output logic      sclk,
  output logic      d,
  output logic      d_oe,
  input  wire logic pin
);
  timeunit 1ns;
  timeprecision 100ps;
  realtime hp  = 62.5; // half link period
  realtime gap = 0;    // stall before second word
  // clock idles low between commands
  initial begin
    sclk = 1'b0;
    d    = 1'b0;
    d_oe = 1'b0;
  end
  // one word out, msb first, changed on the rise
  task automatic send(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      #hp sclk = 1'b1;
      d = w[i];
      d_oe = 1'b1;
      #hp sclk = 1'b0;
    end
  endtask
  // release, wait out busy and ready, clock two words in
  task automatic recv(output logic [15:0] a, output logic [15:0] b);
    logic [31:0] r;
    // let the device sample the last bit, then release before it drives
    #(hp / 4) d_oe = 1'b0;
    #(hp / 2);
    wait (pin === 1'b1);
    wait (pin === 1'b0);
    #23000;
    for (int i = 31; i >= 0; i--) begin
      if (i == 15) #gap;
      #hp sclk = 1'b1;
      r[i] = pin;
      #hp sclk = 1'b0;
    end
    {a, b} = r;
  endtask
endmodule

// ---- tb/tb.sv ----
// self-checking bench for the link device end
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  err_total++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb import pesl_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  logic       ref_clk = 1'b0;
  logic       rst     = 1'b1;
  logic       sclk, pd, pd_oe, pin, dout, doe, busy;
  logic [3:0] last_opcode;
  int         err_total  = 0;
  int         n_compared = 0;
  // device wins, then programmer, else last bit turned over
  assign pin = doe ? dout : (pd_oe ? pd : ~pd);
  pesl_link i_pesl_link (.ref_clk, .rst, .prog_serial_clock_pin(sclk),
    .prog_serial_data_pin_i(pin), .prog_serial_data_pin_o(dout),
    .prog_serial_data_pin_oe(doe), .busy, .last_opcode);
  pesl_prog_model i_pesl_prog_model (.sclk, .d(pd), .d_oe(pd_oe), .pin);
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic final_report;
    if (err_total == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // one command and its response, judged by opcode
  task automatic xfer(input logic [3:0] op, input logic [11:0] len);
    logic [15:0] a, b;
    logic        ok;
    i_pesl_prog_model.send({op, len});
    for (int i = 1; i < len; i++) i_pesl_prog_model.send(16'hA5C3);
    i_pesl_prog_model.recv(a, b);
    ok = op == OPC_SANITY || op == OPC_VERSION;
    `CHK("head", {ok ? 4'h1 : 4'h2, op, 8'h00}, a)
    `CHK("tail", op == OPC_VERSION ? VERSION_W : RESP_LEN2, b)
    `CHK("opcode", op, last_opcode)
  endtask
  // every opcode, lengths one to three
  task automatic t_all_ops;
    for (int k = 0; k < 16; k++) xfer(4'(k), 12'(k % 3 + 1));
  endtask
  // long stall between response words
  task automatic t_stall;
    i_pesl_prog_model.gap = 40000;
    xfer(OPC_SANITY, 12'h001);
    i_pesl_prog_model.gap = 0;
  endtask
  // command cut short, then reset and recovery
  task automatic t_abort;
    i_pesl_prog_model.send(16'h0003);
    i_pesl_prog_model.send(16'h1234);
    #200;
    `CHK("early busy", 1'b0, busy)
    @(posedge ref_clk);
    #1 rst = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 rst = 1'b0;
    i_pesl_prog_model.d_oe = 1'b0;
    `CHK("reset drive", 1'b0, doe)
    repeat (4) @(posedge ref_clk);
    xfer(OPC_VERSION, 12'h001);
  endtask
  // watchdog well past the expected run
  initial begin
    #800us;
    err_total++;
    final_report();
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge ref_clk);
    t_all_ops();
    t_stall();
    t_abort();
    final_report();
  end
endmodule
